// File: src/ddrr_pin_if.sv
`timescale 1ns/1ps
interface ddrr_pin_if;
   logic ck_rise;
   logic cke;
   logic [3:0] cmd;

   modport sync
   (
      output ck_rise,
      output cke,
      output cmd
   );

   modport core
   (
      input ck_rise,
      input cke,
      input cmd
   );
endinterface

// File: src/ddrr_pin_sync.sv
`timescale 1ns/1ps
module ddrr_pin_sync
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic ck_pin,
   input wire logic cke_pin,
   input wire logic [3:0] cmd_pin,
   ddrr_pin_if.sync pins
);
   import ddrr_pkg::*;

   logic [5:0] meta_r;
   logic [5:0] sync_r;
   logic ck_prev_r;

   // first stage feeds only the second stage
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         meta_r <= 6'h3F;
         sync_r <= 6'h3F;
         ck_prev_r <= 1'b1;
      end
      else if (ce)
      begin
         meta_r <= {ck_pin, cke_pin, cmd_pin};
         sync_r <= meta_r;
         ck_prev_r <= sync_r[5];
      end
   end

   assign pins.ck_rise = sync_r[5] & ~ck_prev_r;
   assign pins.cke = sync_r[4];
   assign pins.cmd = sync_r[3:0];
endmodule

// File: src/ddrr_pkg.sv
package ddrr_pkg;

   // device clock and timing figures
   localparam int CORE_CLK_PS = 25000;
   localparam int T_REFI_NS = 7800;
   localparam int T_RFC_NS = 100;
   localparam int T_REFI_CYC = (T_REFI_NS * 1000) / CORE_CLK_PS;
   localparam int T_RFC_CYC = (T_RFC_NS * 1000 + CORE_CLK_PS - 1) / CORE_CLK_PS;

   localparam int ROW_W = 13;
   localparam int BANK_N = 4;
   localparam int CNT_W = 10;

   localparam logic [ROW_W-1:0] ROW_RST = 13'h0000;
   localparam logic [CNT_W-1:0] REFI_LAST = CNT_W'(T_REFI_CYC - 1);
   localparam logic [CNT_W-1:0] RFC_LAST = CNT_W'(T_RFC_CYC - 1);
   localparam logic [CNT_W-1:0] CNT_RST = 10'h000;

   // command pins packed as {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0] CMD_REFRESH = 4'h1;
   localparam logic [3:0] CMD_NOP = 4'h7;

   typedef enum logic [1:0] {
      ST_NORMAL,
      ST_SELF_REF,
      ST_PRE_PD,
      ST_ACT_PD
   } ddrr_state_type;

endpackage

// File: src/ddrr_refresh_pd.sv
`timescale 1ns/1ps
// Operation
// - CKE high plus refresh pins decode auto refresh
// - refresh uses internal row counter, banks idle
// - refresh pins with CKE low enter self refresh
// - self refresh ignores all inputs except CKE and CK, whose rise samples it
// - loop off, internal clock gated in self refresh
// - internal refresh happens within minimum CKE time
// - CKE registered low enters power-down
// - idle banks precharge power-down, else active
// - buffers off; loop kept only in fast exit
// - CKE high with NOP or deselect exits
module ddrr_refresh_pd
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic ck_pin,
   input wire logic cke_pin,
   input wire logic cs_n_pin,
   input wire logic ras_n_pin,
   input wire logic cas_n_pin,
   input wire logic we_n_pin,
   input wire logic [ddrr_pkg::BANK_N-1:0] bank_open,
   input wire logic burst_busy,
   input wire logic mode_set_busy,
   input wire logic apd_fast_exit,
   input wire logic init_done,
   output logic refresh_active_r,
   output logic [ddrr_pkg::ROW_W-1:0] refresh_row_r,
   output logic banks_idle_force_r,
   output logic dll_enable_r,
   output logic int_clk_enable_r,
   output logic io_buf_enable_r,
   output logic self_refresh_r,
   output logic pre_pd_r,
   output logic act_pd_r,
   output logic array_lost_r
);
   import ddrr_pkg::*;

   ddrr_pin_if pins ();

   ddrr_pin_sync u_sync
   (
      .core_clk(core_clk),
      .rstn(rstn),
      .ce(ce),
      .ck_pin(ck_pin),
      .cke_pin(cke_pin),
      .cmd_pin({cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin}),
      .pins(pins.sync)
   );

   ddrr_state_type state_r;
   ddrr_state_type state_nxt;
   logic cke_prev_r;
   logic cke_seen_r;
   logic [CNT_W-1:0] rfc_cnt_r;
   logic [CNT_W-1:0] refi_cnt_r;
   logic is_refresh;
   logic is_nop;
   logic auto_ref;
   logic sref_tick;
   logic start_ref;

   assign is_refresh = (pins.cmd == CMD_REFRESH);
   assign is_nop = pins.cmd[3] | (pins.cmd == CMD_NOP);
   assign auto_ref = pins.ck_rise & (state_r == ST_NORMAL) & cke_prev_r & pins.cke & is_refresh;

   // cke_prev_r registers cke only on link clock rising edges; cke_seen_r samples it every cycle
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         cke_prev_r <= 1'b1;
      else if (ce && pins.ck_rise)
         cke_prev_r <= pins.cke;
   end

   always_comb
   begin
      state_nxt = state_r;
      if (pins.ck_rise)
      begin
         case (state_r)
            ST_NORMAL:
            begin
               if (cke_prev_r && !pins.cke)
               begin
                  if (is_refresh)
                     state_nxt = ST_SELF_REF;
                  else if (bank_open == '0)
                     state_nxt = ST_PRE_PD;
                  else
                     state_nxt = ST_ACT_PD;
               end
            end
            ST_SELF_REF:
            begin
               // command pins are not looked at here
               if (pins.cke)
                  state_nxt = ST_NORMAL;
            end
            ST_PRE_PD, ST_ACT_PD:
            begin
               if (pins.cke && is_nop)
                  state_nxt = ST_NORMAL;
            end
            default:
               state_nxt = ST_NORMAL;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         state_r <= ST_NORMAL;
      else if (ce)
         state_r <= state_nxt;
   end

   // self refresh: first internal refresh right at entry, then every interval
   assign sref_tick = (state_r == ST_SELF_REF) && (refi_cnt_r == CNT_RST);
   assign start_ref = (auto_ref || sref_tick) && !refresh_active_r;

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         refi_cnt_r <= CNT_RST;
      else if (ce)
      begin
         if (state_r != ST_SELF_REF)
            refi_cnt_r <= CNT_RST;
         else if (refi_cnt_r == REFI_LAST)
            refi_cnt_r <= CNT_RST;
         else
            refi_cnt_r <= refi_cnt_r + 10'h001;
      end
   end

   // refresh engine; the external address bus is never sampled
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         refresh_active_r <= 1'b0;
         rfc_cnt_r <= CNT_RST;
         refresh_row_r <= ROW_RST;
         banks_idle_force_r <= 1'b0;
      end
      else if (ce)
      begin
         banks_idle_force_r <= 1'b0;
         if (start_ref)
         begin
            refresh_active_r <= 1'b1;
            rfc_cnt_r <= CNT_RST;
         end
         else if (refresh_active_r)
         begin
            if (rfc_cnt_r == RFC_LAST)
            begin
               refresh_active_r <= 1'b0;
               refresh_row_r <= refresh_row_r + 13'h0001;
               banks_idle_force_r <= 1'b1;
            end
            else
               rfc_cnt_r <= rfc_cnt_r + 10'h001;
         end
      end
   end

   // low-power side effects follow the next state so they line up with entry
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         dll_enable_r <= 1'b1;
         int_clk_enable_r <= 1'b1;
         io_buf_enable_r <= 1'b1;
         self_refresh_r <= 1'b0;
         pre_pd_r <= 1'b0;
         act_pd_r <= 1'b0;
      end
      else if (ce)
      begin
         self_refresh_r <= (state_nxt == ST_SELF_REF);
         pre_pd_r <= (state_nxt == ST_PRE_PD);
         act_pd_r <= (state_nxt == ST_ACT_PD);
         int_clk_enable_r <= (state_nxt != ST_SELF_REF);
         io_buf_enable_r <= (state_nxt == ST_NORMAL);
         case (state_nxt)
            ST_SELF_REF: dll_enable_r <= 1'b0;
            ST_PRE_PD: dll_enable_r <= 1'b0;
            ST_ACT_PD:
            begin
               // the fast exit choice is latched at entry only
               if (state_r != ST_ACT_PD)
                  dll_enable_r <= apd_fast_exit;
            end
            default: dll_enable_r <= 1'b1;
         endcase
      end
   end

   // cke falling outside a registered edge while an access or mode set runs
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         cke_seen_r <= 1'b1;
      else if (ce)
         cke_seen_r <= pins.cke;
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         array_lost_r <= 1'b0;
      else if (ce)
      begin
         // a new loss beats a simultaneous completion of re-initialisation
         if (cke_seen_r && !pins.cke && state_r == ST_NORMAL && (burst_busy || mode_set_busy))
            array_lost_r <= 1'b1;
         else if (init_done)
            array_lost_r <= 1'b0;
      end
   end
endmodule

// File: verif/ddrr_ctrl_model.sv
`timescale 1ns/1ps
module ddrr_ctrl_model
(
   output logic ck_pin,
   output logic cke_pin,
   output logic [3:0] cmd_pins
);
   import ddrr_pkg::*;
   // refresh debt in whole intervals, counted only while cke is high; low-power stays are bounded on their own
   int owed = 0;
   always
   begin
      #(T_REFI_NS);
      if (cke_pin)
         owed++;
   end
   // free running: power-down needs a stable clock throughout
   // one fixed period and no termination pin: termination stays off and the loop never loses lock
   initial
   begin
      ck_pin = 1'h0;
      cke_pin = 1'h1;
      cmd_pins = CMD_NOP;
      #37;
      forever #100 ck_pin = ~ck_pin;
   end
   // pins move only while ck is low, so each rise sees settled levels
   task automatic issue(input logic cke_v, input logic [3:0] cmd_v);
      @(negedge ck_pin);
      if (owed >= 8 && cke_pin)
      begin
         // settle a postponed refresh before anything else so no gap reaches nine intervals
         cmd_pins = CMD_REFRESH;
         owed--;
         @(negedge ck_pin);
         cmd_pins = CMD_NOP;
         @(negedge ck_pin);
      end
      if (cke_pin && cke_v && cmd_v == CMD_REFRESH && owed > 0)
         owed--;
      cke_pin = cke_v;
      cmd_pins = cmd_v;
      @(negedge ck_pin);
      cmd_pins = CMD_NOP;
   endtask
endmodule

// File: verif/ddrr_refresh_pd_properties.sv
`timescale 1ns/1ps
module ddrr_refresh_pd_properties
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic [ddrr_pkg::BANK_N-1:0] bank_open,
   input wire logic apd_fast_exit,
   input wire logic refresh_active_r,
   input wire logic [ddrr_pkg::ROW_W-1:0] refresh_row_r,
   input wire logic banks_idle_force_r,
   input wire logic dll_enable_r,
   input wire logic int_clk_enable_r,
   input wire logic io_buf_enable_r,
   input wire logic self_refresh_r,
   input wire logic pre_pd_r,
   input wire logic act_pd_r
);
   import ddrr_pkg::*;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   sequence s_ref_run; refresh_active_r [*4] ##1 (!refresh_active_r && banks_idle_force_r); endsequence
   property p_ref_len; $rose(refresh_active_r) |-> s_ref_run; endproperty
   a_ref_len: assert property (p_ref_len) else $error("bad refresh length");
   property p_row; $rose(banks_idle_force_r) |-> refresh_row_r == $past(refresh_row_r) + 13'h0001; endproperty
   a_row: assert property (p_row) else $error("bad row step");
   // the entry refresh is launched from the registered state, one cycle behind the flags
   sequence s_sr_first; !dll_enable_r ##1 refresh_active_r; endsequence
   property p_sr_in; $rose(self_refresh_r) |-> s_sr_first; endproperty
   a_sr_in: assert property (p_sr_in) else $error("bad self refresh entry");
   property p_sr; self_refresh_r |-> !(dll_enable_r || int_clk_enable_r || io_buf_enable_r); endproperty
   a_sr: assert property (p_sr) else $error("self refresh not gated");
   property p_pd; (pre_pd_r || act_pd_r) |-> !io_buf_enable_r && int_clk_enable_r; endproperty
   a_pd: assert property (p_pd) else $error("buffers on in power-down");
   property p_pre; $rose(pre_pd_r) |-> $past(bank_open) == 4'h0 && !dll_enable_r; endproperty
   a_pre: assert property (p_pre) else $error("bad precharge power-down");
   property p_act; $rose(act_pd_r) |-> $past(bank_open) != 4'h0 && dll_enable_r == $past(apd_fast_exit); endproperty
   a_act: assert property (p_act) else $error("bad active power-down");
   property p_wake; ($fell(self_refresh_r) || $fell(pre_pd_r) || $fell(act_pd_r)) |-> dll_enable_r; endproperty
   a_wake: assert property (p_wake) else $error("loop off after exit");
endmodule
bind ddrr_refresh_pd ddrr_refresh_pd_properties chk_u (.core_clk, .rstn, .bank_open, .apd_fast_exit,
   .refresh_active_r, .refresh_row_r, .banks_idle_force_r, .dll_enable_r, .int_clk_enable_r, .io_buf_enable_r,
   .self_refresh_r, .pre_pd_r, .act_pd_r);

// File: verif/tb.sv
`timescale 1ns/1ps
module tb;
   import ddrr_pkg::*;
   typedef struct packed
   {
      logic [3:0] bank;
      logic fast;
      logic [3:0] cmd;
      logic [3:0] flags;
   } ddrr_row_type;
   logic core_clk = 1'h0;
   logic rstn = 1'h0;
   logic [3:0] bank_open = 4'h0;
   logic burst_busy = 1'h0;
   logic mode_set_busy = 1'h0;
   logic apd_fast_exit = 1'h0;
   logic init_done = 1'h0;
   logic ce = 1'h1;
   logic ck_pin, cke_pin, refresh_active_r, banks_idle_force_r, dll_enable_r, int_clk_enable_r;
   logic io_buf_enable_r, self_refresh_r, pre_pd_r, act_pd_r, array_lost_r;
   logic [3:0] cmd_pins;
   logic [ROW_W-1:0] refresh_row_r;
   int n_errors = 0;
   int checks_done = 0;
   // flags are {self refresh, precharge pd, active pd, loop enable}
   ddrr_row_type rows [4] = '{'{4'h0, 1'h0, CMD_REFRESH, 4'h8}, '{4'h0, 1'h0, CMD_NOP, 4'h4},
      '{4'h2, 1'h0, CMD_NOP, 4'h2}, '{4'h8, 1'h1, CMD_NOP, 4'h3}};
   always #12.5 core_clk = ~core_clk;
   ddrr_ctrl_model ctrl_u (.ck_pin, .cke_pin, .cmd_pins);
   ddrr_refresh_pd dut_u (.core_clk, .rstn, .ce, .ck_pin, .cke_pin, .cs_n_pin(cmd_pins[3]),
      .ras_n_pin(cmd_pins[2]), .cas_n_pin(cmd_pins[1]), .we_n_pin(cmd_pins[0]), .bank_open, .burst_busy,
      .mode_set_busy, .apd_fast_exit, .init_done, .refresh_active_r, .refresh_row_r, .banks_idle_force_r,
      .dll_enable_r, .int_clk_enable_r, .io_buf_enable_r, .self_refresh_r, .pre_pd_r, .act_pd_r, .array_lost_r);
   task automatic test_done;
      if (n_errors == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic cmp(input logic [23:0] got, input logic [23:0] exp, input string what);
      checks_done++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   initial
   begin
      repeat (20000) @(negedge core_clk);
      n_errors++;
      $display("MISMATCH %0t timeout", $time);
      test_done();
   end
   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   // synchroniser plus registered flags settle well inside six cycles
   task automatic send(input logic k, input logic [3:0] c);
      ctrl_u.issue(k, c);
      cyc(6);
   endtask
   initial
   begin
      cyc(4);
      rstn = 1'h1;
      cyc(1);
      cmp({refresh_active_r, banks_idle_force_r, dll_enable_r, int_clk_enable_r, io_buf_enable_r, self_refresh_r,
         pre_pd_r, act_pd_r, array_lost_r, refresh_row_r}, {9'h070, 13'h0000}, "reset");
      send(1'h1, CMD_REFRESH);
      send(1'h1, CMD_REFRESH);
      cmp(refresh_row_r, 13'h0002, "auto refresh");
      // a frozen block must let a refresh pass by unseen
      ce = 1'h0;
      send(1'h1, CMD_REFRESH);
      ce = 1'h1;
      cyc(2);
      cmp(refresh_row_r, 13'h0002, "frozen");
      foreach (rows[i])
      begin
         bank_open = rows[i].bank;
         apd_fast_exit = rows[i].fast;
         send(1'h0, rows[i].cmd);
         cmp({self_refresh_r, pre_pd_r, act_pd_r, dll_enable_r}, rows[i].flags, "entry");
         send(1'h1, CMD_NOP);
         cmp({self_refresh_r, pre_pd_r, act_pd_r, dll_enable_r, io_buf_enable_r}, 5'h03, "exit");
         bank_open = 4'h0;
      end
      send(1'h1, CMD_REFRESH);
      send(1'h0, CMD_REFRESH);
      send(1'h0, CMD_REFRESH);
      cyc(T_REFI_CYC);
      cmp({self_refresh_r, refresh_row_r}, {1'h1, 13'h0006}, "self refresh");
      send(1'h1, CMD_NOP);
      send(1'h1, CMD_REFRESH);
      send(1'h0, CMD_NOP);
      ctrl_u.issue(1'h1, CMD_REFRESH);
      cyc(2);
      cmp(pre_pd_r, 1'h1, "exit without nop");
      cyc(8);
      cmp(pre_pd_r, 1'h0, "exit with nop");
      for (int i = 0; i < 2; i++)
      begin
         {burst_busy, mode_set_busy} = i ? 2'h1 : 2'h2;
         send(1'h0, CMD_NOP);
         cmp(array_lost_r, 1'h1, "cke drop");
         {burst_busy, mode_set_busy} = 2'h0;
         send(1'h1, CMD_NOP);
         init_done = 1'h1;
         cyc(1);
         init_done = 1'h0;
         cyc(1);
         cmp(array_lost_r, 1'h0, "reinit");
      end
      test_done();
   end
endmodule
